// >>> common/gen_ctrl_status_regs.vh
`ifndef GEN_CTRL_STATUS_REGS_VH
`define GEN_CTRL_STATUS_REGS_VH

// register indices as printed; the byte address on the bus is four times the index
`define GCS_IDX_CONTROL        8'h1c
`define GCS_IDX_STATUS         8'h1d
`define GCS_ADDR_CONTROL       12'h070
`define GCS_ADDR_STATUS        12'h074

// control byte fields
`define GCS_CTRL_CLK_KEEP_BIT  0
`define GCS_CTRL_DEEP_PD_BIT   1
`define GCS_CTRL_RW_MASK       8'h03
`define GCS_CTRL_RESET         8'h00

// status byte fields
`define GCS_STAT_LINK_BIT      0
`define GCS_STAT_SPEED_BIT     1
`define GCS_STAT_DUPLEX_BIT    2
`define GCS_STAT_WIDTH         3

// power states
`define GCS_PSTATE_D0          2'h0
`define GCS_PSTATE_D1          2'h1
`define GCS_PSTATE_D2          2'h2
`define GCS_PSTATE_D3          2'h3

`endif

// >>> src/general_ctrl_status_regs.v
`timescale 1ns/1ps
`include "gen_ctrl_status_regs.vh"
// Summary of operation
// - control byte at index 1Ch; bits 7:2 read zero, bits 1:0 read/write, reset zero
// - with bit 1 set, deep power-down allowed in D2/D3 while link down; never otherwise
// - in deep power-down entered on link loss, link integrity signalling stops
// - with bit 0 set, PCI clock is requested continuously and never released
// - read-only status byte at index 1Dh; bits 7:3 read zero
// - status bit 2 shows duplex: 0 half, 1 full
// - status bit 1 shows speed: 0 for 10 Mbps, 1 for 100 Mbps
// - status bit 0 shows link: 0 down, 1 up
module general_ctrl_status_regs (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_reset,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [3:0]  i_pstrb,
  output wire        o_pready,
  output wire [31:0] o_prdata,
  output wire        o_pslverr,
  // physical layer resolved state (pins)
  input  wire        i_phy_full_duplex,
  input  wire        i_phy_speed_100,
  input  wire        i_phy_link_up,
  // power management and clock run (same clock)
  input  wire [1:0]  i_power_state,
  input  wire        i_clk_request,
  // outputs to the rest of the device
  output wire        o_clk_request,
  output wire        o_deep_power_down,
  output wire        o_link_integrity_en
);

  // power-down sequencer states
  localparam [1:0] ST_ACTIVE = 2'b00;
  localparam [1:0] ST_ENTER  = 2'b01;
  localparam [1:0] ST_DEEP   = 2'b10;

  // address decode, used for both read and write paths
  function [1:0] decode;
    input [11:0] addr;
    begin
      case (addr)
        `GCS_ADDR_CONTROL: decode = 2'b01;
        `GCS_ADDR_STATUS:  decode = 2'b10;
        default:           decode = 2'b00;
      endcase
    end
  endfunction

  // constants brought to the width of the byte they act on
  localparam [7:0] CTRL_RESET   = `GCS_CTRL_RESET;
  localparam [7:0] CTRL_RW_MASK = `GCS_CTRL_RW_MASK;

  reg  [1:0]                ctrl_ff;
  reg  [1:0]                nxt_ctrl;
  reg  [1:0]                pd_state_ff;
  reg  [1:0]                nxt_pd_state;
  reg                       clk_req_ff;
  reg  [31:0]               rdata_ff;
  reg  [31:0]               nxt_rdata;
  wire [`GCS_STAT_WIDTH-1:0] phy_raw;
  wire [`GCS_STAT_WIDTH-1:0] phy_sync;
  wire [1:0]                sel;
  wire                      access;
  wire                      rd_setup;
  wire                      ctrl_wr;
  wire [7:0]                wr_masked;
  wire                      link_down;
  wire                      deep_pd_en;
  wire                      clk_keep_en;
  wire                      nxt_clk_req;
  wire                      low_power_state;
  wire                      pd_allowed;
  wire [7:0]                status_byte;

  assign phy_raw[`GCS_STAT_LINK_BIT]   = i_phy_link_up;
  assign phy_raw[`GCS_STAT_SPEED_BIT]  = i_phy_speed_100;
  assign phy_raw[`GCS_STAT_DUPLEX_BIT] = i_phy_full_duplex;

  // phy pins are asynchronous to the bus clock
  // limitation: a pin change reaches status four clocks late, and a pulse
  // narrower than about two clocks may never be seen by software at all
  genvar g;
  generate
    for (g = 0; g < `GCS_STAT_WIDTH; g = g + 1) begin : g_sync
      pin_sync3 u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (phy_raw[g]),
        .o_level (phy_sync[g])
      );
    end
  endgenerate

  // status follows the synchronised phy state every cycle, no latching
  assign status_byte = {5'h00, phy_sync};

  // apb: zero wait states; unmapped addresses answer with an error
  // pready is tied high, so every transfer ends in its first access cycle
  assign sel       = decode(i_paddr);
  assign access    = i_psel & i_penable;
  assign rd_setup  = i_psel & ~i_penable & ~i_pwrite;
  assign ctrl_wr   = access & i_pwrite & sel[0] & i_pstrb[0];
  assign o_pready  = 1'b1;
  assign o_pslverr = access & (sel == 2'b00);

  // only byte lane 0 carries control bits; the reserved bits are masked off
  // so a write of ones can never make them read back as set, and other
  // lanes hold nothing but reserved bits
  assign wr_masked = i_pwdata[7:0] & CTRL_RW_MASK;

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl = wr_masked[1:0];
    end
    // a write to the status byte is accepted but changes nothing
  end

  always @* begin
    case (sel)
      2'b01:   nxt_rdata = {24'h000000, 6'h00, ctrl_ff};
      2'b10:   nxt_rdata = {24'h000000, status_byte};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_ff <= CTRL_RESET[1:0];
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // read data is taken in the setup cycle and then stands through the access
  // phase, so a phy pin moving mid-transfer cannot change the returned word;
  // the cost is that status is one clock older than the access edge
  always @(posedge i_clk) begin
    if (i_reset) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_setup) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_prdata = rdata_ff;

  // decoded control bits and link state, named for the logic that uses them
  assign deep_pd_en  = ctrl_ff[`GCS_CTRL_DEEP_PD_BIT];
  assign clk_keep_en = ctrl_ff[`GCS_CTRL_CLK_KEEP_BIT];
  assign link_down   = ~phy_sync[`GCS_STAT_LINK_BIT];

  // deep power-down may only be used in D2 or D3 with the link down
  assign low_power_state = (i_power_state == `GCS_PSTATE_D2) || (i_power_state == `GCS_PSTATE_D3);
  assign pd_allowed = deep_pd_en & low_power_state & link_down;

  // the enter state gives one cycle of notice before the link side goes quiet
  always @* begin
    nxt_pd_state = pd_state_ff;
    case (pd_state_ff)
      ST_ACTIVE: begin
        if (pd_allowed) begin
          nxt_pd_state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (pd_allowed) begin
          nxt_pd_state = ST_DEEP;
        end else begin
          nxt_pd_state = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        // link up, leaving D2/D3 or clearing the bit all wake the device
        if (!pd_allowed) begin
          nxt_pd_state = ST_ACTIVE;
        end
      end
      default: nxt_pd_state = ST_ACTIVE;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      pd_state_ff <= ST_ACTIVE;
    end else begin
      pd_state_ff <= nxt_pd_state;
    end
  end

  assign o_deep_power_down   = (pd_state_ff == ST_DEEP);
  // integrity signalling stops only in the deep state, so the link partner
  // sees the link drop only once the device has chosen to sleep
  assign o_link_integrity_en = (pd_state_ff != ST_DEEP);

  // with the keep bit set the request is never given back: idle power is traded
  // for freedom from receive overruns while a stopped clock restarts slowly
  assign nxt_clk_req = clk_keep_en | i_clk_request;

  // registered so the clock request pin never glitches on a bus write
  always @(posedge i_clk) begin
    if (i_reset) begin
      clk_req_ff <= 1'b0;
    end else begin
      clk_req_ff <= nxt_clk_req;
    end
  end

  assign o_clk_request = clk_req_ff;

endmodule // general_ctrl_status_regs

// >>> src/pin_sync3.v
`timescale 1ns/1ps
// three-flop synchroniser; output changes only when stages two and three agree
module pin_sync3 (
  // clock and reset
  input  wire i_clk,
  input  wire i_reset,
  // pin side
  input  wire i_pin,
  // clock domain side
  output wire o_level
);

  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg level_ff;

  always @(posedge i_clk) begin
    if (i_reset) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
      level_ff  <= 1'b0;
    end else begin
      stage1_ff <= i_pin;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff) begin
        level_ff <= stage3_ff;
      end
    end
  end

  assign o_level = level_ff;

endmodule // pin_sync3

// >>> testbench/gcs_props.sv
`timescale 1ns/1ps
module gcs_props (
  input wire        i_clk, i_reset, i_psel, i_penable, i_pwrite, i_clk_request, o_pready, o_pslverr,
  input wire        o_clk_request, o_deep_power_down, o_link_integrity_en,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata, o_prdata,
  input wire [3:0]  i_pstrb,
  input wire [1:0]  i_power_state
);
  wire acc = i_psel & i_penable;
  wire rdc = acc & !i_pwrite & i_paddr == 12'h070;
  wire rds = acc & !i_pwrite & i_paddr == 12'h074;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ready_now_a: assert property (acc |-> o_pready) else $error("no ready");
  ctrl_zero_a: assert property (rdc |-> !o_prdata[31:2]) else $error("ctrl rsvd");
  stat_zero_a: assert property (rds |-> !o_prdata[31:3]) else $error("stat rsvd");
  bad_addr_a: assert property (acc & i_paddr[11:3] != 9'h00e |-> o_pslverr) else $error("no error");
  clk_wish_a: assert property (i_clk_request |=> o_clk_request) else $error("clk wish");
  clk_keep_a: assert property (acc & i_pwrite & rdc == 0 & i_paddr == 12'h070 & i_pstrb[0] & i_pwdata[0]
    |-> ##2 o_clk_request) else $error("clk keep");
  pd_awake_a: assert property (!i_power_state[1] |=> !o_deep_power_down) else $error("pd awake");
  pd_link_a: assert property (!o_link_integrity_en |-> o_deep_power_down && $past(i_power_state[1])) else $error("integrity");
  cover property (o_deep_power_down);
  cover property (rds);
  cover property (o_pslverr);
endmodule // gcs_props
bind general_ctrl_status_regs gcs_props u_props (
  .i_clk               (i_clk),
  .i_reset             (i_reset),
  .i_psel              (i_psel),
  .i_penable           (i_penable),
  .i_pwrite            (i_pwrite),
  .i_clk_request       (i_clk_request),
  .o_pready            (o_pready),
  .o_pslverr           (o_pslverr),
  .o_clk_request       (o_clk_request),
  .o_deep_power_down   (o_deep_power_down),
  .o_link_integrity_en (o_link_integrity_en),
  .i_paddr             (i_paddr),
  .i_pwdata            (i_pwdata),
  .o_prdata            (o_prdata),
  .i_pstrb             (i_pstrb),
  .i_power_state       (i_power_state)
);

// >>> testbench/general_ctrl_status_regs_tb.sv
`timescale 1ns/1ps
`include "gen_ctrl_status_regs.vh"
module general_ctrl_status_regs_tb;
  localparam [11:0] ca = `GCS_ADDR_CONTROL, sa = `GCS_ADDR_STATUS;
  reg         i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_clk_request = 0, err;
  reg  [11:0] i_paddr = 0;
  reg  [31:0] i_pwdata = 0, rd;
  reg  [3:0]  i_pstrb = 0;
  reg  [1:0]  i_power_state = 0;
  reg  [2:0]  cfg = 0;
  wire [31:0] o_prdata;
  wire        o_pready, o_pslverr, o_clk_request, o_deep_power_down, o_link_integrity_en;
  wire        i_phy_full_duplex, i_phy_speed_100, i_phy_link_up;
  integer     fails = 0, n_tests = 0, cyc = 0, k;
  always #12.5 i_clk = ~i_clk;
  general_ctrl_status_regs i_dut (
    .i_clk               (i_clk),
    .i_reset             (i_reset),
    .i_psel              (i_psel),
    .i_penable           (i_penable),
    .i_pwrite            (i_pwrite),
    .i_paddr             (i_paddr),
    .i_pwdata            (i_pwdata),
    .i_pstrb             (i_pstrb),
    .o_pready            (o_pready),
    .o_prdata            (o_prdata),
    .o_pslverr           (o_pslverr),
    .i_phy_full_duplex   (i_phy_full_duplex),
    .i_phy_speed_100     (i_phy_speed_100),
    .i_phy_link_up       (i_phy_link_up),
    .i_power_state       (i_power_state),
    .i_clk_request       (i_clk_request),
    .o_clk_request       (o_clk_request),
    .o_deep_power_down   (o_deep_power_down),
    .o_link_integrity_en (o_link_integrity_en)
  );
  phy_stub u_phy (.i_clk(i_clk), .i_cfg(cfg), .o_pins({i_phy_full_duplex, i_phy_speed_100, i_phy_link_up}));
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    @(posedge i_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk);
    i_penable <= 1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task t_ctrl;
    apb(0, ca, 0, 0);
    chk("ctrl reset", rd, 0);
    apb(1, ca, 32'hffffffff, 4'he);
    apb(0, ca, 0, 0);
    chk("ctrl no strobe", rd, 0);
    apb(1, ca, 32'hffffffff, 4'hf);
    apb(0, ca, 0, 0);
    chk("ctrl rw", rd, 3);
    apb(1, ca, 0, 4'hf);
    apb(0, 12'h078, 0, 0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
  endtask
  task t_stat;
    for (k = 0; k < 8; k = k + 1) begin
      cfg <= k[2:0];
      repeat (8) @(posedge i_clk);
      apb(1, sa, 32'hff, 4'hf);
      chk("status write err", err, 0);
      apb(0, sa, 0, 0);
      chk("status", rd, k);
    end
  endtask
  task t_power;
    i_power_state <= `GCS_PSTATE_D3;
    apb(1, ca, 2, 4'hf);
    repeat (8) @(posedge i_clk);
    chk("pd link up", {o_deep_power_down, o_link_integrity_en}, 1);
    cfg <= 3'h6;
    repeat (10) @(posedge i_clk);
    chk("deep pd", {o_deep_power_down, o_link_integrity_en}, 2);
    i_power_state <= `GCS_PSTATE_D1;
    repeat (3) @(posedge i_clk);
    chk("pd in d1", {o_deep_power_down, o_link_integrity_en}, 1);
    i_power_state <= `GCS_PSTATE_D3;
    repeat (4) @(posedge i_clk);
    chk("deep pd again", o_deep_power_down, 1);
    cfg <= 3'h7;
    repeat (8) @(posedge i_clk);
    chk("pd link back", {o_deep_power_down, o_link_integrity_en}, 1);
    cfg <= 3'h6;
    i_power_state <= `GCS_PSTATE_D2;
    apb(1, ca, 0, 4'hf);
    repeat (8) @(posedge i_clk);
    chk("pd bit clear", {o_deep_power_down, o_link_integrity_en}, 1);
  endtask
  task t_clk;
    apb(1, ca, 1, 4'hf);
    repeat (3) @(posedge i_clk);
    chk("clk keep", o_clk_request, 1);
    repeat (20) @(posedge i_clk);
    chk("clk kept", o_clk_request, 1);
    apb(1, ca, 0, 4'hf);
    repeat (3) @(posedge i_clk);
    chk("clk release", o_clk_request, 0);
    i_clk_request <= 1;
    repeat (3) @(posedge i_clk);
    chk("clk wish", o_clk_request, 1);
    i_clk_request <= 0;
    repeat (3) @(posedge i_clk);
    chk("clk wish gone", o_clk_request, 0);
  endtask
  task t_reset;
    apb(1, ca, 3, 4'hf);
    repeat (3) @(posedge i_clk);
    chk("pd before reset", {o_deep_power_down, o_clk_request}, 3);
    i_reset <= 1;
    repeat (4) @(posedge i_clk);
    i_reset <= 0;
    chk("pd clk after reset", {o_deep_power_down, o_link_integrity_en, o_clk_request}, 2);
    apb(0, ca, 0, 0);
    chk("ctrl after reset", rd, 0);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the roughly 250 cycles the tests need
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 0;
    t_ctrl;
    t_stat;
    t_power;
    t_clk;
    t_reset;
    print_verdict;
  end
endmodule // general_ctrl_status_regs_tb

// >>> testbench/phy_stub.sv
`timescale 1ns/1ps
module phy_stub (
  input  wire       i_clk,
  input  wire [2:0] i_cfg,
  output reg  [2:0] o_pins
);
  // pins move on the clock so the synchroniser delay stays fixed
  always @(posedge i_clk) o_pins <= i_cfg;
endmodule // phy_stub
